// ### abr_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// port checks for the read command block
// ----------------------------------------------------------------------------
module abr_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        media_req,
  input wire logic        media_log,
  input wire logic [47:0] media_lba,
  input wire logic [16:0] media_count,
  input wire logic        media_word_valid,
  input wire logic        media_word_ready,
  input wire logic        dma_valid,
  input wire logic [15:0] dma_data,
  input wire logic        dma_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // bus request shapes
  sequence s_write_req;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  endsequence
  sequence s_reg_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[7:2] != 6'h00;
  endsequence
  sequence s_data_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[7:2] == 6'h00;
  endsequence
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_request: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_write_ack_next: assert property (s_write_req |=> wb_ack_o)
    else $error("write not acked in the next cycle");
  a_reg_read_prompt: assert property (s_reg_read |=> wb_ack_o)
    else $error("register read not acked in the next cycle");
  a_fetch_single: assert property (media_req |=> !media_req [*4])
    else $error("fetch request repeated");
  a_fetch_stable: assert property (media_req |=> $stable(media_lba) && $stable(media_count))
    else $error("fetch address or count moved");
  a_count_range: assert property (media_req |-> media_count != 17'h0 && media_count <= 17'h10000)
    else $error("fetch count out of range");
  a_pop_on_read: assert property (media_word_valid && media_word_ready && !media_log |-> s_data_read ##1 wb_ack_o)
    else $error("media word taken without a data read");
  a_dma_hold: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_data))
    else $error("dma word dropped or changed while stalled");
endmodule : abr_checker

bind abr_core abr_checker i_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .media_req(media_req), .media_log(media_log),
  .media_lba(media_lba), .media_count(media_count), .media_word_valid(media_word_valid),
  .media_word_ready(media_word_ready), .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready));

// ### abr_core.sv
`timescale 1ns/100ps
`include "abr_params.svh"

// Overview of operation
// - opcode 47h written to the command register starts the log-page read by DMA, using the loaded command block.
// - the log-page read by DMA fetches the same log content with the same parameters as the programmed log read.
// - opcode C4h written to the command register starts the multi-sector read.
// - the multi-sector read fetches one block of sectors from the medium, hands its data to the host, then fetches the next block.
// - sector data leaves through the data register as one 16-bit word per host access.
// - one interrupt is raised per block, the block being the sector count set in the block-size register.
// - besides interrupt granularity the read keeps the usual addressing, status and error behaviour.
// - opcode 29h starts the 48-bit multi-sector read with the same per-block interrupts.
// - a 16-bit sector count of zero on the 48-bit read means 65,536 sectors.
// - an unrecoverable error loads the first failing address, low bytes read with the high-order select clear.
module abr_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  output logic             media_req,
  output logic             media_log,
  output logic      [47:0] media_lba,
  output logic      [16:0] media_count,
  input  wire logic        media_done,
  input  wire logic        media_err,
  input  wire logic [47:0] media_err_lba,
  input  wire logic        media_word_valid,
  input  wire logic [15:0] media_word_data,
  output logic             media_word_ready,
  output logic             dma_valid,
  output logic      [15:0] dma_data,
  input  wire logic        dma_ready
);

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  function automatic logic abr_hit(input logic [7:0] adr, input logic [7:0] off);
    abr_hit = (adr[7:2] == off[7:2]);
  endfunction : abr_hit

  abr_pkg::abr_state_t state_reg, state_next;
  abr_pkg::abr_cmd_t   cmd_reg;

  logic [7:0]  sc_cur_reg, sc_prev_reg, lo_cur_reg, lo_prev_reg;
  logic [7:0]  mid_cur_reg, mid_prev_reg, hi_cur_reg, hi_prev_reg;
  logic [7:0]  dev_reg, devctl_reg, blk_reg, err_reg;
  logic [2:0]  irq_st_reg, irq_msk_reg;
  logic        fail_reg;
  logic [47:0] lba_reg;
  logic [16:0] left_reg, nblk_reg;
  logic [24:0] words_reg;
  logic        ack_reg, req_reg, dvalid_reg;
  logic [31:0] rdat_reg;
  logic [15:0] ddata_reg;

  wire req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire busy     = ~state_reg[0];
  wire high_order_byte_select      = devctl_reg[`ABR_DEVCTL_HOB];
  wire hit_data = abr_hit(wb_adr_i, `ABR_OFF_DATA);
  wire pio_rd   = req & ~wb_we_i & hit_data & state_reg[3] & (words_reg != 25'h0);
  wire stall    = pio_rd & ~media_word_valid;
  wire go       = req & ~stall;
  wire wr       = go & wb_we_i;
  wire wr_b0    = wr & wb_sel_i[0];
  wire tf_wr    = wr_b0 & ~busy;   // task file ignores writes while busy
  wire pio_pop  = go & pio_rd;

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  wire        cmd_wr  = tf_wr & abr_hit(wb_adr_i, `ABR_OFF_CMD);
  wire [7:0]  op      = wb_dat_i[7:0];
  wire        op_log  = (op == `ABR_OP_LOG_DMA);
  wire        op_mult = (op == `ABR_OP_RD_MULT);
  wire        op_mulx = (op == `ABR_OP_RD_MULTX);
  wire [15:0] sc16    = {sc_prev_reg, sc_cur_reg};
  wire        no_blk  = (blk_reg == `ABR_RST_BLKSIZE);
  wire        op_bad  = ~(op_log | op_mult | op_mulx) | (op_log & (sc16 == 16'h0000)) | (~op_log & no_blk);
  wire        start   = cmd_wr & ~op_bad;
  wire        abort   = cmd_wr & op_bad;

  // count: 28-bit zero means 256, 48-bit zero means 65,536
  wire [16:0] cnt_mult = (sc_cur_reg == 8'h00) ? 17'h00100 : {9'h000, sc_cur_reg};
  wire [16:0] cnt_mulx = (sc16 == 16'h0000) ? 17'h10000 : {1'b0, sc16};
  wire [16:0] cnt_new  = op_log ? {1'b0, sc16} : (op_mulx ? cnt_mulx : cnt_mult);

  // address: log reads carry page and log address like the programmed log read
  wire [47:0] lba_log  = {24'h000000, mid_prev_reg, mid_cur_reg, lo_cur_reg};
  wire [47:0] lba_28   = {20'h00000, dev_reg[3:0], hi_cur_reg, mid_cur_reg, lo_cur_reg};
  wire [47:0] lba_48   = {hi_prev_reg, mid_prev_reg, lo_prev_reg, hi_cur_reg, mid_cur_reg, lo_cur_reg};
  wire [47:0] lba_new  = op_log ? lba_log : (op_mulx ? lba_48 : lba_28);

  // block length for the next fetch: log reads fetch everything at once
  wire [16:0] blk17    = {9'h000, blk_reg};
  wire [16:0] nblk     = (cmd_reg == abr_pkg::CMD_LOG) ? left_reg :
                         ((left_reg < blk17) ? left_reg : blk17);

  // --------------------------------------------------------------------------
  // media and dma handshake
  // --------------------------------------------------------------------------
  wire dma_load  = state_reg[4] & media_word_valid & (words_reg != 25'h0) & (~dvalid_reg | dma_ready);
  wire fetch_ok  = state_reg[2] & media_done & ~media_err;
  wire fetch_bad = state_reg[2] & media_done & media_err;
  wire blk_end   = state_reg[3] & (words_reg == 25'h0);
  wire dma_end   = state_reg[4] & (words_reg == 25'h0) & ~dvalid_reg;

  assign media_word_ready = pio_pop | dma_load;

  // --------------------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------------------
  // next state: fetch a block, wait for the medium, then let the host drain it
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      abr_pkg::ST_IDLE: if (start) state_next = abr_pkg::ST_REQ;
      abr_pkg::ST_REQ:  state_next = abr_pkg::ST_WAIT;
      abr_pkg::ST_WAIT: begin
        if (fetch_bad) begin
          state_next = abr_pkg::ST_IDLE;
        end else if (fetch_ok) begin
          state_next = (cmd_reg == abr_pkg::CMD_LOG) ? abr_pkg::ST_DMA : abr_pkg::ST_PIO;
        end
      end
      abr_pkg::ST_PIO: begin
        if (blk_end) begin
          state_next = (left_reg == 17'h0) ? abr_pkg::ST_IDLE : abr_pkg::ST_REQ;
        end
      end
      abr_pkg::ST_DMA:  if (dma_end) state_next = abr_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= abr_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // command, address, sector and word counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_reg   <= abr_pkg::CMD_MULT;
      lba_reg   <= 48'h0;
      left_reg  <= 17'h0;
      nblk_reg  <= 17'h0;
      words_reg <= 25'h0;
    end else if (start) begin
      cmd_reg  <= op_log ? abr_pkg::CMD_LOG : (op_mulx ? abr_pkg::CMD_MULX : abr_pkg::CMD_MULT);
      lba_reg  <= lba_new;
      left_reg <= cnt_new;
    end else if (state_reg[1]) begin
      nblk_reg <= nblk;
      left_reg <= left_reg - nblk;
    end else if (fetch_ok) begin
      words_reg <= {nblk_reg, 8'h00};   // 256 words per sector
      if (cmd_reg != abr_pkg::CMD_LOG) begin
        lba_reg <= lba_reg + {31'h0, nblk_reg};
      end
    end else if (pio_pop | dma_load) begin
      words_reg <= words_reg - 25'h1;
    end
  end

  // fetch request towards the medium
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg     <= 1'b0;
      media_lba   <= 48'h0;
      media_count <= 17'h0;
      media_log   <= 1'b0;
    end else begin
      req_reg <= state_reg[1];
      if (state_reg[1]) begin
        media_lba   <= lba_reg;
        media_count <= nblk;
        media_log   <= (cmd_reg == abr_pkg::CMD_LOG);
      end
    end
  end

  assign media_req = req_reg;

  // dma output stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dvalid_reg <= 1'b0;
      ddata_reg  <= 16'h0;
    end else if (dma_load) begin
      dvalid_reg <= 1'b1;
      ddata_reg  <= media_word_data;
    end else if (dma_ready) begin
      dvalid_reg <= 1'b0;
    end
  end

  assign dma_valid = dvalid_reg;
  assign dma_data  = ddata_reg;

  // --------------------------------------------------------------------------
  // task file registers
  // --------------------------------------------------------------------------
  // writes push the current byte into the previous one; a failure loads the address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_cur_reg   <= `ABR_RST_BYTE;
      sc_prev_reg  <= `ABR_RST_BYTE;
      lo_cur_reg   <= `ABR_RST_BYTE;
      lo_prev_reg  <= `ABR_RST_BYTE;
      mid_cur_reg  <= `ABR_RST_BYTE;
      mid_prev_reg <= `ABR_RST_BYTE;
      hi_cur_reg   <= `ABR_RST_BYTE;
      hi_prev_reg  <= `ABR_RST_BYTE;
    end else if (fetch_bad) begin
      {hi_prev_reg, mid_prev_reg, lo_prev_reg} <= media_err_lba[47:24];
      {hi_cur_reg, mid_cur_reg, lo_cur_reg}    <= media_err_lba[23:0];
    end else if (tf_wr) begin
      if (abr_hit(wb_adr_i, `ABR_OFF_SCOUNT)) begin
        sc_prev_reg <= sc_cur_reg;
        sc_cur_reg  <= wb_dat_i[7:0];
      end
      if (abr_hit(wb_adr_i, `ABR_OFF_LBA_LO)) begin
        lo_prev_reg <= lo_cur_reg;
        lo_cur_reg  <= wb_dat_i[7:0];
      end
      if (abr_hit(wb_adr_i, `ABR_OFF_LBA_MID)) begin
        mid_prev_reg <= mid_cur_reg;
        mid_cur_reg  <= wb_dat_i[7:0];
      end
      if (abr_hit(wb_adr_i, `ABR_OFF_LBA_HI)) begin
        hi_prev_reg <= hi_cur_reg;
        hi_cur_reg  <= wb_dat_i[7:0];
      end
    end
  end

  // device, control and block-size registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_reg    <= `ABR_RST_BYTE;
      devctl_reg <= `ABR_RST_BYTE;
      blk_reg    <= `ABR_RST_BLKSIZE;
    end else begin
      if (tf_wr & abr_hit(wb_adr_i, `ABR_OFF_DEVICE))  dev_reg <= wb_dat_i[7:0];
      if (tf_wr & abr_hit(wb_adr_i, `ABR_OFF_BLKSIZE)) blk_reg <= wb_dat_i[7:0];
      if (wr_b0 & abr_hit(wb_adr_i, `ABR_OFF_DEVCTL))  devctl_reg <= wb_dat_i[7:0];
    end
  end

  // error byte of an aborted command: only the abort bit
  wire [7:0] err_abort = 8'(1 << `ABR_ERR_ABT);

  // error report and failure flag, cleared by each started command, set by an aborted one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_reg  <= `ABR_RST_BYTE;
      fail_reg <= 1'b0;
    end else if (abort) begin
      err_reg  <= err_abort;   // aborted
      fail_reg <= 1'b1;
    end else if (start) begin
      err_reg  <= `ABR_RST_BYTE;
      fail_reg <= 1'b0;
    end else if (fetch_bad) begin
      err_reg[`ABR_ERR_UNC] <= 1'b1;
      fail_reg              <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  wire [2:0] ev;
  assign ev[`ABR_IRQ_BLOCK] = fetch_ok & (cmd_reg != abr_pkg::CMD_LOG);
  assign ev[`ABR_IRQ_DONE]  = dma_end;
  assign ev[`ABR_IRQ_FAIL]  = fetch_bad | abort;

  wire [2:0] irq_clr = (wr_b0 & abr_hit(wb_adr_i, `ABR_OFF_IRQ_ST)) ? wb_dat_i[2:0] : 3'h0;

  // sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_st_reg  <= `ABR_RST_IRQ;
      irq_msk_reg <= `ABR_RST_IRQ;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | ev;
      if (wr_b0 & abr_hit(wb_adr_i, `ABR_OFF_IRQ_MSK)) irq_msk_reg <= wb_dat_i[2:0];
    end
  end

  assign irq = |(irq_st_reg & irq_msk_reg);

  // --------------------------------------------------------------------------
  // bus read data and acknowledge
  // --------------------------------------------------------------------------
  // status busy bit drops while a block is drained through the data register, so busy and data request never show together
  wire       bsy_flag    = busy & ~state_reg[3];
  wire [7:0] drive_state = {bsy_flag, 1'b1, 1'b0, 1'b1, state_reg[3], 2'b00, fail_reg};

  wire [7:0] rd_byte =
    abr_hit(wb_adr_i, `ABR_OFF_ERROR)   ? err_reg :
    abr_hit(wb_adr_i, `ABR_OFF_SCOUNT)  ? (high_order_byte_select ? sc_prev_reg : sc_cur_reg) :
    abr_hit(wb_adr_i, `ABR_OFF_LBA_LO)  ? (high_order_byte_select ? lo_prev_reg : lo_cur_reg) :
    abr_hit(wb_adr_i, `ABR_OFF_LBA_MID) ? (high_order_byte_select ? mid_prev_reg : mid_cur_reg) :
    abr_hit(wb_adr_i, `ABR_OFF_LBA_HI)  ? (high_order_byte_select ? hi_prev_reg : hi_cur_reg) :
    abr_hit(wb_adr_i, `ABR_OFF_DEVICE)  ? dev_reg :
    abr_hit(wb_adr_i, `ABR_OFF_CMD)     ? drive_state :
    abr_hit(wb_adr_i, `ABR_OFF_DEVCTL)  ? devctl_reg :
    abr_hit(wb_adr_i, `ABR_OFF_BLKSIZE) ? blk_reg :
    abr_hit(wb_adr_i, `ABR_OFF_IRQ_ST)  ? {5'h00, irq_st_reg} :
    abr_hit(wb_adr_i, `ABR_OFF_IRQ_MSK) ? {5'h00, irq_msk_reg} : 8'h00;

  wire [31:0] rd_word = hit_data ? {16'h0000, (pio_rd ? media_word_data : 16'h0000)} : {24'h000000, rd_byte};

  // one ack per request, read data captured on the same edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ack_reg <= go;
      if (go & ~wb_we_i) rdat_reg <= rd_word;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

endmodule : abr_core

// ### abr_media_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// storage medium: fetch delay, then a word stream of lba[15:0]+index
// ----------------------------------------------------------------------------
module abr_media_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        fail,
  input  wire logic        media_req,
  input  wire logic [47:0] media_lba,
  input  wire logic [16:0] media_count,
  output logic             media_done,
  output logic             media_err,
  output logic      [47:0] media_err_lba,
  output logic             media_word_valid,
  output logic      [15:0] media_word_data,
  input  wire logic        media_word_ready
);
  logic [24:0] left_reg;
  logic [15:0] base_reg, idx_reg, last_reg;
  logic [47:0] bad_reg;
  logic [2:0]  wait_reg;
  logic        tog_reg;
  // fetch first, stream only after a clean finish
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {left_reg, base_reg, idx_reg, last_reg, bad_reg, wait_reg, tog_reg, media_done, media_err} <= '0;
    end else begin
      media_done <= 1'b0;
      media_err <= 1'b0;
      tog_reg <= ~tog_reg;
      if (media_req) begin
        wait_reg <= 3'h4;
        base_reg <= media_lba[15:0];
        bad_reg <= media_lba + 48'h1;
        idx_reg <= 16'h0;
      end else if (wait_reg != 3'h0) begin
        wait_reg <= wait_reg - 3'h1;
      end
      if (!media_req && wait_reg == 3'h1) begin
        media_done <= 1'b1;
        media_err <= fail;
        left_reg <= fail ? 25'h0 : {media_count, 8'h00};
      end
      if (media_word_valid && media_word_ready) begin
        left_reg <= left_reg - 25'h1;
        idx_reg <= idx_reg + 16'h1;
        last_reg <= media_word_data;
      end
    end
  end
  // stale values are inverted so no leftover word passes for a fresh one
  assign media_word_valid = left_reg != 25'h0 && !(slow && tog_reg);
  assign media_word_data  = media_word_valid ? base_reg + idx_reg : ~last_reg;
  assign media_err_lba    = media_err ? bad_reg : ~bad_reg;
endmodule : abr_media_model

// ### abr_params.svh
`ifndef ABR_PARAMS_SVH
`define ABR_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ABR_OFF_DATA     8'h00
`define ABR_OFF_ERROR    8'h04
`define ABR_OFF_SCOUNT   8'h08
`define ABR_OFF_LBA_LO   8'h0C
`define ABR_OFF_LBA_MID  8'h10
`define ABR_OFF_LBA_HI   8'h14
`define ABR_OFF_DEVICE   8'h18
`define ABR_OFF_CMD      8'h1C
`define ABR_OFF_DEVCTL   8'h20
`define ABR_OFF_BLKSIZE  8'h24
`define ABR_OFF_IRQ_ST   8'h28
`define ABR_OFF_IRQ_MSK  8'h2C

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define ABR_OP_LOG_DMA   8'h47
`define ABR_OP_RD_MULT   8'hC4
`define ABR_OP_RD_MULTX  8'h29

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ABR_ERR_UNC      6
`define ABR_ERR_ABT      2
`define ABR_ST_BSY       7
`define ABR_ST_RDY       6
`define ABR_ST_DSC       4
`define ABR_ST_DRQ       3
`define ABR_ST_ERR       0
`define ABR_DEVCTL_HOB   7
`define ABR_IRQ_BLOCK    0
`define ABR_IRQ_DONE     1
`define ABR_IRQ_FAIL     2

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define ABR_RST_BYTE     8'h00
`define ABR_RST_BLKSIZE  8'h00
`define ABR_RST_IRQ      3'h0
`define ABR_SECT_SHIFT   8

`endif

// ### abr_pkg.sv
package abr_pkg;

  // command sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_REQ  = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_PIO  = 5'b01000,
    ST_DMA  = 5'b10000
  } abr_state_t;

  // command being executed
  typedef enum logic [1:0] {
    CMD_LOG  = 2'h0,
    CMD_MULT = 2'h1,
    CMD_MULX = 2'h2
  } abr_cmd_t;

endpackage : abr_pkg

// ### ata_block_read_commands_bench.sv
`timescale 1ns/100ps
`include "abr_params.svh"
// ----------------------------------------------------------------------------
// bench: host register traffic against the read command block
// ----------------------------------------------------------------------------
module ata_block_read_commands_bench;
  logic        clk, rst, cyc, stb, we, slow, fail, dma_ready;
  logic [7:0]  adr;
  logic [31:0] wdat, wb_dat_o;
  logic        ack, irq, mreq, mlog, mdone, merr, mvalid, mready, dma_valid;
  logic [47:0] mlba, merr_lba;
  logic [16:0] mcount;
  logic [15:0] mdata, dma_data;
  int          failures, checks_done, dma_n;

  abr_core i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .irq(irq), .media_req(mreq),
    .media_log(mlog), .media_lba(mlba), .media_count(mcount), .media_done(mdone), .media_err(merr),
    .media_err_lba(merr_lba), .media_word_valid(mvalid), .media_word_data(mdata), .media_word_ready(mready),
    .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready));
  abr_media_model i_media (.clk(clk), .rst(rst), .slow(slow), .fail(fail), .media_req(mreq), .media_lba(mlba),
    .media_count(mcount), .media_done(mdone), .media_err(merr), .media_err_lba(merr_lba),
    .media_word_valid(mvalid), .media_word_data(mdata), .media_word_ready(mready));

  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rc
  task automatic wait_idle;
    logic [31:0] q;
    repeat (2) @(posedge clk);
    do acc(1'b0, `ABR_OFF_CMD, 32'h0, q); while (q[7] !== 1'b0);
  endtask : wait_idle

  // clock, stalling dma sink and its checker
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) dma_ready <= ~dma_ready;
  always @(posedge clk) begin
    if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
      chk({16'h0, dma_data}, 32'(32'h310 + dma_n));
      dma_n++;
    end
  end
  initial begin
    #200000;
    failures++;
    conclude();
  end

  // main sequence
  initial begin
    {cyc, stb, we, slow, fail, dma_ready, adr, wdat} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc(`ABR_OFF_CMD, 32'h50);
    rc(`ABR_OFF_BLKSIZE, 32'h0);
    rc(`ABR_OFF_IRQ_MSK, 32'h0);
    rc(8'h3C, 32'h0);
    rc(`ABR_OFF_DATA, 32'h0);
    wr(`ABR_OFF_IRQ_MSK, 32'h7);
    wr(`ABR_OFF_CMD, `ABR_OP_RD_MULT);
    wait_idle();
    rc(`ABR_OFF_ERROR, 32'h04);
    rc(`ABR_OFF_CMD, 32'h51);
    chk({31'h0, irq}, 32'h1);
    wr(`ABR_OFF_IRQ_MSK, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(`ABR_OFF_IRQ_ST, 32'h4);
    wr(`ABR_OFF_IRQ_MSK, 32'h7);
    chk({31'h0, irq}, 32'h0);
    // two one-sector blocks with a slow medium
    slow <= 1'b1;
    wr(`ABR_OFF_BLKSIZE, 32'h1);
    wr(`ABR_OFF_SCOUNT, 32'h2);
    wr(`ABR_OFF_LBA_LO, 32'h20);
    wr(`ABR_OFF_LBA_MID, 32'h01);
    wr(`ABR_OFF_LBA_HI, 32'h00);
    wr(`ABR_OFF_DEVICE, 32'h40);
    wr(`ABR_OFF_CMD, `ABR_OP_RD_MULT);
    for (int b = 0; b < 2; b++) begin
      while (irq !== 1'b1) @(posedge clk);
      wr(`ABR_OFF_IRQ_ST, 32'h1);
      chk({15'h0, mcount}, 32'h1);
      rc(`ABR_OFF_CMD, 32'h58);
      for (int i = 0; i < 256; i++) rc(`ABR_OFF_DATA, 32'(32'h120 + b + i));
    end
    wait_idle();
    rc(`ABR_OFF_IRQ_ST, 32'h0);
    // 48-bit read of 65,536 sectors failing on the first block
    fail <= 1'b1;
    wr(`ABR_OFF_BLKSIZE, 32'h2);
    wr(`ABR_OFF_SCOUNT, 32'h0);
    wr(`ABR_OFF_SCOUNT, 32'h0);
    for (int r = 0; r < 3; r++) begin
      wr(8'(`ABR_OFF_LBA_LO + 4 * r), 32'(4 + r));
      wr(8'(`ABR_OFF_LBA_LO + 4 * r), 32'(1 + r));
    end
    wr(`ABR_OFF_CMD, `ABR_OP_RD_MULTX);
    wait_idle();
    chk({15'h0, mcount}, 32'h2);
    chk(mlba[47:16], 32'h06050403);
    rc(`ABR_OFF_ERROR, 32'h40);
    rc(`ABR_OFF_CMD, 32'h51);
    for (int h = 0; h < 2; h++) begin
      wr(`ABR_OFF_DEVCTL, h ? 32'h80 : 32'h00);
      rc(`ABR_OFF_LBA_LO, h ? 32'h04 : 32'h02);
      rc(`ABR_OFF_LBA_MID, h ? 32'h05 : 32'h02);
      rc(`ABR_OFF_LBA_HI, h ? 32'h06 : 32'h03);
    end
    // log page by dma into a stalling sink
    fail <= 1'b0;
    wr(`ABR_OFF_DEVCTL, 32'h0);
    wr(`ABR_OFF_IRQ_ST, 32'h7);
    wr(`ABR_OFF_SCOUNT, 32'h0);
    wr(`ABR_OFF_SCOUNT, 32'h1);
    wr(`ABR_OFF_LBA_LO, 32'h10);
    wr(`ABR_OFF_LBA_MID, 32'h00);
    wr(`ABR_OFF_LBA_MID, 32'h03);
    wr(`ABR_OFF_CMD, `ABR_OP_LOG_DMA);
    while (irq !== 1'b1) @(posedge clk);
    rc(`ABR_OFF_IRQ_ST, 32'h2);
    chk(32'(dma_n), 32'd256);
    chk({8'h0, mlba[23:0]}, 32'h310);
    chk({31'h0, mlog}, 32'h1);
    // unknown opcode and an empty log count both abort without a fetch
    wr(`ABR_OFF_CMD, 32'hA5);
    rc(`ABR_OFF_ERROR, 32'h04);
    wr(`ABR_OFF_SCOUNT, 32'h0);
    wr(`ABR_OFF_SCOUNT, 32'h0);
    wr(`ABR_OFF_CMD, `ABR_OP_LOG_DMA);
    rc(`ABR_OFF_CMD, 32'h51);
    rc(`ABR_OFF_IRQ_ST, 32'h6);
    chk({8'h0, mlba[23:0]}, 32'h310);
    conclude();
  end
endmodule : ata_block_read_commands_bench
